// ---- rtl/eer_i2c_client.sv ----
// Bus client: reads, pointer, high-speed entry, protection word
`timescale 1ns/1ps
module eer_i2c_client
  import eer_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  input wire logic WP,
  input wire logic CLIENT_SELECT_PIN_2,
  input wire logic CLIENT_SELECT_PIN_1,
  input wire logic CLIENT_SELECT_PIN_0,
  input wire logic WR_BUSY,
  output logic [15:0] MEM_ADDR,
  output logic MEM_RD_STB,
  input wire logic [7:0] MEM_RD_DATA,
  input wire logic MEM_ECC_HIT,
  output logic WR_BYTE_STB,
  output logic [15:0] WR_ADDR,
  output logic [7:0] WR_DATA,
  output logic WR_CYCLE_START,
  output logic HS_MODE,
  output logic [15:0] PROTECTION_CONFIGURATION_WORD
);
  logic [5:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic [2:0] sel_pins;

  eer_sync #(.WIDTH(6)) u_sync (
    .clk(REF_CLK),
    .srst(SRST),
    .d({SCL, SDA_IN, WP, CLIENT_SELECT_PIN_2, CLIENT_SELECT_PIN_1,
        CLIENT_SELECT_PIN_0}),
    .q(pins_s)
  );

  assign scl_s = pins_s[5];
  assign sda_s = pins_s[4];
  assign wp_s = pins_s[3];
  assign sel_pins = pins_s[2:0];

  eer_state_e state_q, state_d;
  eer_kind_e kind_q, kind_d;
  logic scl_p_q, scl_p_d, sda_p_q, sda_p_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d, whi_q, whi_d;
  logic rw_q, rw_d, cfg_tgt_q, cfg_tgt_d, ack_q, ack_d;
  logic oe_n_q, oe_n_d, hs_q, hs_d, sel_q, sel_d;
  logic cfg_ok_q, cfg_ok_d, cfg_idx_q, cfg_idx_d;
  logic [15:0] ptr_q, ptr_d, cfg_q, cfg_d, wr_addr_q, wr_addr_d;
  logic [2:0] dcnt_q, dcnt_d;
  logic [7:0] b0_q, b0_d, b1_q, b1_d, cf_q, cf_d, wr_data_q, wr_data_d;
  logic rd_stb_q, rd_stb_d, wr_stb_q, wr_stb_d, wr_cyc_q, wr_cyc_d;

  logic scl_rise, scl_fall, start_ev, stop_ev;
  logic is_hs_code, match_arr, match_cfg, arr_prot, confirm_ok;
  logic [2:0] zone;
  logic [7:0] zone_bits, load_byte;

  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;
  assign start_ev = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_ev = scl_s && scl_p_q && !sda_p_q && sda_s;

  assign is_hs_code = (sh_q[7:3] == HS_CODE_PFX);
  assign match_arr = (sh_q[7:4] == ARRAY_TYPE_ID) && (sh_q[3:1] == sel_pins);
  assign match_cfg = (sh_q[7:4] == CFG_TYPE_ID) && (sh_q[3:1] == sel_pins);

  // Zone from the page being written; pages never straddle zones
  assign zone = ptr_q[ZONE_MSB:ZONE_LSB];
  assign zone_bits = cfg_q[7:0];
  assign arr_prot = cfg_q[CFG_MODE_BIT] ? zone_bits[zone] : wp_s;
  assign confirm_ok = b0_q[CFG_LOCK_BIT-8] ? (cf_q == CONFIRM_LOCK)
                                           : (cf_q == CONFIRM_OPEN);
  assign load_byte = cfg_tgt_q ? (cfg_idx_q ? cfg_q[7:0] : cfg_q[15:8])
                               : MEM_RD_DATA;

  always_comb
  begin
    state_d = state_q;
    kind_d = kind_q;
    scl_p_d = scl_s;
    sda_p_d = sda_s;
    cnt_d = cnt_q;
    sh_d = sh_q;
    tx_d = tx_q;
    whi_d = whi_q;
    rw_d = rw_q;
    cfg_tgt_d = cfg_tgt_q;
    ack_d = ack_q;
    oe_n_d = oe_n_q;
    hs_d = hs_q;
    sel_d = sel_q;
    cfg_ok_d = cfg_ok_q;
    cfg_idx_d = cfg_idx_q;
    ptr_d = ptr_q;
    cfg_d = cfg_q;
    wr_addr_d = wr_addr_q;
    dcnt_d = dcnt_q;
    b0_d = b0_q;
    b1_d = b1_q;
    cf_d = cf_q;
    wr_data_d = wr_data_q;
    rd_stb_d = 1'b0;
    wr_stb_d = 1'b0;
    wr_cyc_d = 1'b0;
    if (start_ev)
    begin
      // Repeated start keeps high-speed mode and aborts any write
      state_d = ST_RX;
      kind_d = KIND_DEV;
      cnt_d = 4'h0;
      dcnt_d = 3'h0;
      sel_d = 1'b0;
      oe_n_d = 1'b1;
    end
    else if (stop_ev)
    begin
      if (sel_q && !rw_q && !cfg_tgt_q && dcnt_q != 3'h0)
      begin
        wr_cyc_d = !arr_prot;
      end
      if (sel_q && !rw_q && cfg_tgt_q && dcnt_q == CFG_DATA_BYTES &&
          cfg_ok_q && !cfg_q[CFG_LOCK_BIT] && confirm_ok)
      begin
        // Pin and zone bits play no part here
        cfg_d = {cfg_q[CFG_ECC_BIT], 5'h00, b0_q[1:0], b1_q};
      end
      hs_d = 1'b0;
      state_d = ST_IDLE;
      sel_d = 1'b0;
      dcnt_d = 3'h0;
      oe_n_d = 1'b1;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          oe_n_d = 1'b1;
        end
        ST_RX:
        begin
          if (scl_rise && cnt_q != BITS_PER_BYTE)
          begin
            sh_d = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end
          else if (scl_fall && cnt_q == BITS_PER_BYTE)
          begin
            state_d = ST_RACK;
            cnt_d = 4'h0;
            ack_d = 1'b1;
            case (kind_q)
              KIND_DEV:
              begin
                // Busy device answers no header and no host code
                ack_d = !WR_BUSY && !is_hs_code && (match_arr || match_cfg);
                if (is_hs_code && !WR_BUSY)
                begin
                  hs_d = 1'b1;
                end
                rw_d = sh_q[0];
                cfg_tgt_d = match_cfg;
                sel_d = !WR_BUSY && !is_hs_code && (match_arr || match_cfg);
                cfg_idx_d = 1'b0;
              end
              KIND_WHI:
              begin
                whi_d = sh_q;
              end
              KIND_WLO:
              begin
                if (!cfg_tgt_q)
                begin
                  ptr_d = {whi_q, sh_q};
                end
                cfg_ok_d = whi_q[WA_A15_POS] && whi_q[WA_A11_POS] &&
                           !whi_q[WA_A10_POS];
              end
              default:
              begin
                if (dcnt_q != DCNT_MAX)
                begin
                  dcnt_d = dcnt_q + 3'h1;
                end
                if (!cfg_tgt_q)
                begin
                  wr_stb_d = 1'b1;
                  wr_data_d = sh_q;
                  wr_addr_d = ptr_q;
                  ptr_d = {ptr_q[15:PAGE_MSB+1], ptr_q[PAGE_MSB:0] + 7'h01};
                end
                else if (dcnt_q == 3'h0)
                begin
                  b0_d = sh_q;
                end
                else if (dcnt_q == 3'h1)
                begin
                  b1_d = sh_q;
                end
                else if (dcnt_q == 3'h2)
                begin
                  cf_d = sh_q;
                end
              end
            endcase
            oe_n_d = !ack_d;
          end
        end
        ST_RACK:
        begin
          if (scl_fall)
          begin
            oe_n_d = 1'b1;
            if (!ack_q)
            begin
              state_d = ST_IDLE;
            end
            else if (kind_q == KIND_DEV && rw_q)
            begin
              tx_d = load_byte;
              oe_n_d = load_byte[7];
              state_d = ST_TX;
              if (!cfg_tgt_q)
              begin
                rd_stb_d = 1'b1;
                cfg_d[CFG_ECC_BIT] = MEM_ECC_HIT;
              end
            end
            else
            begin
              state_d = ST_RX;
              if (kind_q != KIND_DATA)
              begin
                kind_d = eer_kind_e'(kind_q + 2'h1);
              end
            end
          end
        end
        ST_TX:
        begin
          if (scl_fall)
          begin
            if (cnt_q == LAST_TX_BIT)
            begin
              oe_n_d = 1'b1;
              cnt_d = 4'h0;
              state_d = ST_TXACK;
            end
            else
            begin
              tx_d = {tx_q[6:0], 1'b0};
              oe_n_d = tx_q[6];
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        ST_TXACK:
        begin
          if (scl_rise)
          begin
            if (!cfg_tgt_q)
            begin
              ptr_d = ptr_q + 16'h0001;
            end
            else
            begin
              cfg_idx_d = !cfg_idx_q;
            end
            state_d = sda_s ? ST_IDLE : ST_TXLD;
          end
        end
        ST_TXLD:
        begin
          if (scl_fall)
          begin
            tx_d = load_byte;
            oe_n_d = load_byte[7];
            state_d = ST_TX;
            if (!cfg_tgt_q)
            begin
              rd_stb_d = 1'b1;
              cfg_d[CFG_ECC_BIT] = MEM_ECC_HIT;
            end
          end
        end
        default:
        begin
          state_d = ST_IDLE;
          oe_n_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      state_q <= ST_IDLE;
      kind_q <= KIND_DEV;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      whi_q <= 8'h00;
      rw_q <= 1'b0;
      cfg_tgt_q <= 1'b0;
      ack_q <= 1'b0;
      oe_n_q <= 1'b1;
      hs_q <= 1'b0;
      sel_q <= 1'b0;
      cfg_ok_q <= 1'b0;
      cfg_idx_q <= 1'b0;
      ptr_q <= PTR_RESET;
      cfg_q <= CFG_RESET;
      wr_addr_q <= PTR_RESET;
      dcnt_q <= 3'h0;
      b0_q <= 8'h00;
      b1_q <= 8'h00;
      cf_q <= 8'h00;
      wr_data_q <= 8'h00;
      rd_stb_q <= 1'b0;
      wr_stb_q <= 1'b0;
      wr_cyc_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      kind_q <= kind_d;
      scl_p_q <= scl_p_d;
      sda_p_q <= sda_p_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      whi_q <= whi_d;
      rw_q <= rw_d;
      cfg_tgt_q <= cfg_tgt_d;
      ack_q <= ack_d;
      oe_n_q <= oe_n_d;
      hs_q <= hs_d;
      sel_q <= sel_d;
      cfg_ok_q <= cfg_ok_d;
      cfg_idx_q <= cfg_idx_d;
      ptr_q <= ptr_d;
      cfg_q <= cfg_d;
      wr_addr_q <= wr_addr_d;
      dcnt_q <= dcnt_d;
      b0_q <= b0_d;
      b1_q <= b1_d;
      cf_q <= cf_d;
      wr_data_q <= wr_data_d;
      rd_stb_q <= rd_stb_d;
      wr_stb_q <= wr_stb_d;
      wr_cyc_q <= wr_cyc_d;
    end
  end

  // Open-drain data line: only ever pulled low
  assign SDA_OUT = 1'b0;
  assign SDA_OE_N = oe_n_q;
  assign MEM_ADDR = ptr_q;
  assign MEM_RD_STB = rd_stb_q;
  assign WR_BYTE_STB = wr_stb_q;
  assign WR_ADDR = wr_addr_q;
  assign WR_DATA = wr_data_q;
  assign WR_CYCLE_START = wr_cyc_q;
  assign HS_MODE = hs_q;
  assign PROTECTION_CONFIGURATION_WORD = cfg_q;

  AST_ZONE_BLOCK: assert property (@(posedge REF_CLK) disable iff (SRST)
    (wr_cyc_q && cfg_q[CFG_MODE_BIT]) |-> !zone_bits[$past(zone)])
    else $error("Write cycle started in a protected zone");

  AST_LEGACY_PIN: assert property (@(posedge REF_CLK) disable iff (SRST)
    (wr_cyc_q && !cfg_q[CFG_MODE_BIT]) |-> !$past(wp_s))
    else $error("Write cycle started with guard pin high");

  AST_LOCK_FROZEN: assert property (@(posedge REF_CLK) disable iff (SRST)
    $past(cfg_q[CFG_LOCK_BIT]) |-> (cfg_q[9:0] == $past(cfg_q[9:0])))
    else $error("Locked configuration word changed");

  AST_RSVD_ZERO: assert property (@(posedge REF_CLK) disable iff (SRST)
    cfg_q[CFG_RSVD_MSB:CFG_RSVD_LSB] == 5'h00)
    else $error("Reserved configuration bits not zero");

  AST_HS_NO_ACK: assert property (@(posedge REF_CLK) disable iff (SRST)
    (state_q == ST_RACK && kind_q == KIND_DEV && is_hs_code) |-> SDA_OE_N)
    else $error("Host code was acknowledged");

  AST_HS_BUSY: assert property (@(posedge REF_CLK) disable iff (SRST)
    (state_q == ST_RX && scl_fall && cnt_q == BITS_PER_BYTE && !start_ev &&
     !stop_ev && kind_q == KIND_DEV && WR_BUSY && !hs_q) |=> !hs_q)
    else $error("High-speed entered during write cycle");

  AST_HS_EXIT: assert property (@(posedge REF_CLK) disable iff (SRST)
    stop_ev |=> (!HS_MODE && state_q == ST_IDLE) [*2])
    else $error("High-speed mode survived a stop");

  AST_HS_HOLD: assert property (@(posedge REF_CLK) disable iff (SRST)
    (hs_q && start_ev) |=> hs_q)
    else $error("Repeated start left high-speed mode");

  AST_PTR_STEP: assert property (@(posedge REF_CLK) disable iff (SRST)
    (state_q == ST_TXACK && scl_rise && !cfg_tgt_q) |=>
      (ptr_q == $past(ptr_q) + 16'h0001))
    else $error("Pointer did not advance by one after a byte");

  AST_NACK_IDLE: assert property (@(posedge REF_CLK) disable iff (SRST)
    (state_q == ST_TXACK && scl_rise && sda_s) |=>
      (state_q == ST_IDLE && SDA_OE_N))
    else $error("Read did not end on host nack");

  AST_ACK_HEADER: assert property (@(posedge REF_CLK) disable iff (SRST)
    (state_q == ST_RACK && kind_q == KIND_DEV && ack_q) |-> !SDA_OE_N)
    else $error("Matching header not acknowledged");
endmodule

// ---- rtl/eer_pkg.sv ----
// Constants and types for the serial EEPROM client bus logic
// Summary of operation
// - Mode select set: array splits into eight zones, each with own protect bit.
// - Zone bit n guards the 8-Kbyte range starting at n times 2000h.
// - Zone bits never block security or configuration register writes.
// - Address pointer holds last accessed address plus one.
// - Matching read header: acknowledge, then shift out byte at pointer.
// - Host withholds acknowledge: read ends, device goes to standby.
// - Write header with word address then repeated start loads pointer only.
// - After random read, pointer holds last read address plus one.
// - Each host acknowledge advances pointer and sends next byte.
// - Sequential read past the top address wraps pointer to zero.
// - High-speed host code is never acknowledged.
// - After host code: high-speed filtering, wait for repeated start.
// - High-speed mode holds across repeated starts until stop or reset.
// - High-speed entry code is ignored while a write cycle runs.
// - A 16-bit protection configuration word is read and written.
// - Configuration header: type 1011b, three select pins, read/write bit.
// - Configuration word address: A15 and A11 high, A10 low, rest ignored.
// - Once locked, configuration word is permanently read-only.
// - Bit 15 ECC flag, 9 mode, 8 lock, 7:0 zones; 14:10 zero.
// - Config write needs two data bytes plus 99h or 66h confirmation.
// - Mode select clear: write-guard pin high protects the whole array.
// - Protected writes are acknowledged but start no write cycle.
package eer_pkg;

  localparam logic [3:0] ARRAY_TYPE_ID = 4'hA;
  localparam logic [3:0] CFG_TYPE_ID = 4'hB;
  localparam logic [4:0] HS_CODE_PFX = 5'h01;

  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam int CFG_ECC_BIT = 15;
  localparam int CFG_MODE_BIT = 9;
  localparam int CFG_LOCK_BIT = 8;
  localparam int CFG_RSVD_MSB = 14;
  localparam int CFG_RSVD_LSB = 10;
  localparam logic [7:0] CONFIRM_LOCK = 8'h99;
  localparam logic [7:0] CONFIRM_OPEN = 8'h66;

  // Positions inside the high word address byte
  localparam int WA_A15_POS = 7;
  localparam int WA_A11_POS = 3;
  localparam int WA_A10_POS = 2;

  localparam int ZONE_MSB = 15;
  localparam int ZONE_LSB = 13;
  localparam int PAGE_MSB = 6;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam logic [2:0] CFG_DATA_BYTES = 3'h3;
  localparam logic [2:0] DCNT_MAX = 3'h7;
  localparam logic [15:0] PTR_RESET = 16'h0000;

  typedef enum logic [1:0] {
    KIND_DEV = 2'h0,
    KIND_WHI = 2'h1,
    KIND_WLO = 2'h2,
    KIND_DATA = 2'h3
  } eer_kind_e;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX = 6'h02,
    ST_RACK = 6'h04,
    ST_TX = 6'h08,
    ST_TXACK = 6'h10,
    ST_TXLD = 6'h20
  } eer_state_e;

endpackage

// ---- rtl/eer_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module eer_sync #(
  parameter int WIDTH = 6
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb
  begin
    meta_d = d;
    sync_d = meta_q;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta_q <= '1;
      sync_q <= '1;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q = sync_q;
endmodule

// ---- verification/eer_host_model.sv ----
// Bus host model: start, stop, byte write and byte read on SCL and SDA
`timescale 1ns/1ps
module eer_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Also serves as repeated start after a nack
  task automatic start();
    tick(3);
    sda_low <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda_low <= 1'b1;
    tick(3);
    scl <= 1'b0;
  endtask

  // Ends every write and leaves high speed
  task automatic stop();
    tick(3);
    sda_low <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda_low <= 1'b0;
    tick(3);
  endtask

  // Released line floats high through the pull-up
  task automatic bit_io(input logic b, output logic s);
    tick(3);
    sda_low <= ~b;
    tick(3);
    scl <= 1'b1;
    tick(3);
    s = sda;
    tick(3);
    scl <= 1'b0;
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // Host withholds ack on the last byte to end a read
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~ack, s);
  endtask
endmodule

// ---- verification/test_eer_i2c_client.sv ----
// Testbench for the serial EEPROM bus client
`timescale 1ns/1ps
module test_eer_i2c_client;
  import eer_pkg::*;
  logic REF_CLK = 1'b0;
  logic SRST = 1'b1;
  logic SCL, SDA_OUT, SDA_OE_N, WP = 1'b0, WR_BUSY = 1'b0, sda_low, sda;
  logic MEM_RD_STB, WR_BYTE_STB, WR_CYCLE_START, HS_MODE;
  logic [15:0] MEM_ADDR, WR_ADDR, cfg;
  logic [7:0] MEM_RD_DATA = 8'h00, WR_DATA;
  int err_total = 0;
  int checks_done = 0;
  logic [15:0] wcs = 16'h0000;
  logic ecc_hit = 1'b0;
  localparam logic [2:0] SEL = 3'b101;

  initial
  begin
    forever #2 REF_CLK = ~REF_CLK;
  end

  assign sda = (SDA_OE_N === 1'b0 || sda_low) ? 1'b0 : 1'b1;

  eer_host_model host (.clk(REF_CLK), .sda(sda), .scl(SCL),
    .sda_low(sda_low));

  eer_i2c_client DUT (.REF_CLK(REF_CLK), .SRST(SRST), .SCL(SCL),
    .SDA_IN(sda), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .WP(WP),
    .CLIENT_SELECT_PIN_2(SEL[2]), .CLIENT_SELECT_PIN_1(SEL[1]),
    .CLIENT_SELECT_PIN_0(SEL[0]), .WR_BUSY(WR_BUSY),
    .MEM_ADDR(MEM_ADDR), .MEM_RD_STB(MEM_RD_STB),
    .MEM_RD_DATA(MEM_RD_DATA), .MEM_ECC_HIT(ecc_hit),
    .WR_BYTE_STB(WR_BYTE_STB), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA),
    .WR_CYCLE_START(WR_CYCLE_START), .HS_MODE(HS_MODE),
    .PROTECTION_CONFIGURATION_WORD(cfg));

  function automatic logic [7:0] mem_b(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction

  // Array model answers one cycle after the pointer moves
  always @(posedge REF_CLK)
  begin
    MEM_RD_DATA <= mem_b(MEM_ADDR);
    if (WR_CYCLE_START === 1'b1) wcs <= wcs + 16'h0001;
  end

  task automatic chk(input logic [15:0] got, exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report();
    $display("Compares %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Header byte with expected ack
  task automatic hdr(input logic [3:0] typ, input logic rd, input logic ak);
    logic a;
    host.start();
    host.wr_byte({typ, SEL, rd}, a);
    chk(a, ak, "header ack");
  endtask

  // Host code byte, never acknowledged
  task automatic hs_code();
    logic a;
    host.start();
    host.wr_byte({HS_CODE_PFX, 3'b010}, a);
    chk(a, 1'b0, "host code ack");
  endtask

  // Write header, word address, n data bytes, stop
  task automatic wr(input logic [3:0] typ, input logic [15:0] adr,
    input logic [23:0] d, input int n);
    logic a;
    hdr(typ, 1'b0, 1'b1);
    host.wr_byte(adr[15:8], a);
    host.wr_byte(adr[7:0], a);
    for (int i = 0; i < n; i++)
    begin
      host.wr_byte(d[23-8*i -: 8], a);
      chk(a, 1'b1, "data ack");
    end
    host.stop();
    host.tick(4);
  endtask

  task automatic rd(input logic ak, input logic [7:0] exp);
    logic [7:0] d;
    host.rd_byte(ak, d);
    chk(d, exp, "read byte");
  endtask

  initial
  begin
    logic a;
    repeat (16) @(posedge REF_CLK);
    SRST <= 1'b0;
    host.tick(2);
    chk(cfg, CFG_RESET, "cfg reset");
    chk(MEM_ADDR, PTR_RESET, "ptr reset");
    chk(HS_MODE, 1'b0, "hs reset");
    $display("test reset done");
    // Legacy guard pin
    WP <= 1'b1;
    wr(ARRAY_TYPE_ID, 16'h1234, 24'h11_0000, 1);
    chk(wcs, 0, "guarded write");
    WP <= 1'b0;
    wr(ARRAY_TYPE_ID, 16'h1234, 24'h22_0000, 1);
    chk(wcs, 1, "open write");
    $display("test legacy done");
    // Configuration writes: good, bad confirm, short, bad address
    wr(CFG_TYPE_ID, 16'h8800, {8'h02, 8'h15, CONFIRM_OPEN}, 3);
    chk(cfg, 16'h0215, "cfg write");
    wr(CFG_TYPE_ID, 16'h8800, {8'h03, 8'hFF, CONFIRM_OPEN}, 3);
    wr(CFG_TYPE_ID, 16'hFFFF, {8'h02, 8'h00, 8'h00}, 2);
    wr(CFG_TYPE_ID, 16'h0C00, {8'h02, 8'h00, CONFIRM_OPEN}, 3);
    chk(cfg, 16'h0215, "cfg unchanged");
    hdr(CFG_TYPE_ID, 1'b1, 1'b1);
    rd(1'b1, 8'h02);
    rd(1'b0, 8'h15);
    host.stop();
    $display("test config done");
    // Zones 0, 2 and 4 guarded
    wr(ARRAY_TYPE_ID, 16'h4010, 24'h33_4400, 2);
    wr(ARRAY_TYPE_ID, 16'h0000, 24'h44_0000, 1);
    wr(ARRAY_TYPE_ID, 16'h9FFF, 24'h55_0000, 1);
    chk(wcs, 1, "zone guard");
    wr(ARRAY_TYPE_ID, 16'h2000, 24'h66_0000, 1);
    wr(ARRAY_TYPE_ID, 16'hE000, 24'h77_0000, 1);
    chk(wcs, 3, "zone open");
    $display("test zones done");
    // Random read at the top, wrap, then current address read
    hdr(ARRAY_TYPE_ID, 1'b0, 1'b1);
    host.wr_byte(8'hFF, a);
    host.wr_byte(8'hFF, a);
    hdr(ARRAY_TYPE_ID, 1'b1, 1'b1);
    rd(1'b1, mem_b(16'hFFFF));
    rd(1'b0, mem_b(16'h0000));
    host.stop();
    chk(wcs, 3, "no write on read");
    chk(MEM_ADDR, 16'h0001, "ptr after read");
    ecc_hit <= 1'b1;
    hdr(ARRAY_TYPE_ID, 1'b1, 1'b1);
    rd(1'b0, mem_b(16'h0001));
    ecc_hit <= 1'b0;
    chk(cfg, 16'h8215, "ecc flag set");
    host.start();
    hdr(ARRAY_TYPE_ID, 1'b1, 1'b1);
    rd(1'b0, mem_b(16'h0002));
    host.stop();
    chk(cfg, 16'h0215, "ecc flag clear");
    $display("test reads done");
    // High speed entry, repeated start, exit by stop
    hs_code();
    chk(HS_MODE, 1'b1, "hs entry");
    hdr(ARRAY_TYPE_ID, 1'b1, 1'b1);
    rd(1'b0, mem_b(16'h0003));
    chk(HS_MODE, 1'b1, "hs holds");
    host.stop();
    host.tick(6);
    chk(HS_MODE, 1'b0, "hs exit");
    WR_BUSY <= 1'b1;
    hs_code();
    chk(HS_MODE, 1'b0, "hs while busy");
    hdr(ARRAY_TYPE_ID, 1'b0, 1'b0);
    host.stop();
    WR_BUSY <= 1'b0;
    $display("test high speed done");
    // Lock with all zones guarded, then try to change
    wr(CFG_TYPE_ID, 16'h8800, {8'h03, 8'hFF, CONFIRM_LOCK}, 3);
    chk(cfg, 16'h03FF, "cfg lock");
    wr(CFG_TYPE_ID, 16'h8800, {8'h02, 8'h00, CONFIRM_OPEN}, 3);
    chk(cfg, 16'h03FF, "cfg locked");
    wr(ARRAY_TYPE_ID, 16'h2000, 24'h88_0000, 1);
    chk(wcs, 3, "all zones");
    $display("test lock done");
    final_report();
  end

  initial
  begin
    repeat (60000) @(posedge REF_CLK);
    err_total++;
    final_report();
  end
endmodule
